// ==== tcc_pkg.sv ====
// constants and types for the 16-bit timer capture/compare block
// Overview of operation
// - capture trigger is capture pin, or comparator output when select bit set
// - changing trigger source may capture; software clears capture flag afterwards
// - filter enable adds four system clock cycles before edge detection
// - edge detector disabled only in modes using capture as ceiling; filter keeps running
// - software driving the capture pin port can trigger a capture
// - filter output changes only when four consecutive samples agree
// - every capture overwrites the capture value, read or not
// - writing one clears capture flag; writing zero leaves it
// - enabled set compare flag requests irq; cleared by ack or write-one
// - compare channel a can serve as counter ceiling
// - compare values double buffered in pwm modes, direct otherwise
// - buffered compare loads only at ceiling or floor
// - compare reads return buffer or register directly, no latch
// - high byte write fills latch; low byte write moves it up
// - force strobe in non-pwm modes updates level, no flag, no counter effect
// - count write blocks every compare match in the next timer tick
// - count written equal to variable ceiling misses it, runs to 0xffff
// - compare output level kept across waveform mode changes
// - output action bits act immediately, not buffered
// - capture copies count and sets flag in the same cycle
// - reset clears each compare output level to zero
package tcc_pkg;
   localparam int          CNT_W        = 16;
   localparam int          BYTE_W       = 8;
   localparam int          NUM_CH       = 2;
   localparam int          FILT_LEN     = 4;
   localparam logic [15:0] CNT_MAX      = 16'hffff;
   localparam logic [15:0] CNT_FLOOR    = 16'h0000;
   localparam logic [15:0] CMP_RST      = 16'h0000;
   // waveform mode encodings
   localparam logic [3:0]  WGM_NORMAL   = 4'h0;
   localparam logic [3:0]  WGM_CTC_A    = 4'h4;
   localparam logic [3:0]  WGM_PFC_ICR  = 4'h8;
   localparam logic [3:0]  WGM_PC_ICR   = 4'ha;
   localparam logic [3:0]  WGM_CTC_ICR  = 4'hc;
   localparam logic [3:0]  WGM_FAST_ICR = 4'he;
   // output actions
   localparam logic [1:0]  ACT_NONE     = 2'h0;
   localparam logic [1:0]  ACT_TOGGLE   = 2'h1;
   localparam logic [1:0]  ACT_CLEAR    = 2'h2;
   localparam logic [1:0]  ACT_SET      = 2'h3;
   typedef enum logic [2:0] {
      CAP_IDLE = 3'b001,
      CAP_WAIT = 3'b010,
      CAP_HOLD = 3'b100
   } tcc_cap_state_t;
endpackage : tcc_pkg

// ==== tcc_filter.sv ====
// four-sample noise filter for the capture input
`timescale 1ns/1ps
module tcc_filter #(
   parameter int LEN = tcc_pkg::FILT_LEN
) (
   input  wire logic ref_clk,  // system clock
   input  wire logic rst,      // async reset, high
   input  wire logic clk_en,   // freezes state when low
   input  wire logic din,      // synchronised input
   output logic      dout      // filtered level
);
   logic [LEN-1:0] hist_reg;
   logic [LEN-1:0] hist_next;
   logic           out_reg;
   logic           out_next;

   always_comb begin
      hist_next = {hist_reg[LEN-2:0], din};
      out_next  = out_reg;
      // all samples equal
      // newest sample included, so the filter costs exactly four cycles
      if (&hist_next) begin
         out_next = 1'b1;
      end else if (~|hist_next) begin
         out_next = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hist_reg <= '0;
         out_reg  <= 1'b0;
      end else if (clk_en) begin
         hist_reg <= hist_next;
         out_reg  <= out_next;
      end
   end

   assign dout = out_reg;
endmodule : tcc_filter

// ==== tcc_capture_compare.sv ====
// capture and compare channels of the 16-bit timer
`timescale 1ns/1ps
module tcc_capture_compare (
   input  wire logic        ref_clk,                 // system clock 25 MHz
   input  wire logic        rst,                     // async reset, high
   input  wire logic        clk_en,                  // global clock enable
   input  wire logic        timer_tick,              // prescaled timer strobe
   input  wire logic [15:0] count_value,             // counter value
   input  wire logic        count_write,             // cpu wrote count
   input  wire logic [3:0]  waveform_mode,           // mode select
   input  wire logic        capture_pin,             // async pin
   input  wire logic        comparator_output,       // async comparator
   input  wire logic        comparator_capture_select, // use comparator
   input  wire logic        capture_filter_enable,   // filter on
   input  wire logic        capture_edge_rising,     // edge polarity
   input  wire logic        capture_flag_clr,        // write one to flag
   input  wire logic        capture_irq_ack,         // irq executed
   input  wire logic        capture_irq_enable,      // capture irq enable
   input  wire logic [7:0]  wr_data,                 // cpu write byte
   input  wire logic [1:0]  cmp_high_wr,             // per channel high write
   input  wire logic [1:0]  cmp_low_wr,              // per channel low write
   input  wire logic [1:0]  compare_flag_clr,        // write one per channel
   input  wire logic [1:0]  compare_irq_ack,         // irq executed
   input  wire logic [1:0]  compare_irq_enable,      // per channel enable
   input  wire logic [3:0]  compare_output_action,   // two bits per channel
   input  wire logic [1:0]  force_compare_strobe,    // per channel strobe
   input  wire logic        at_ceiling,              // counter at ceiling
   input  wire logic        at_floor,                // counter at floor
   output logic [15:0]      capture_value,           // captured count
   output logic             capture_flag,            // capture flag
   output logic             capture_irq,             // capture irq
   output logic [31:0]      compare_value,           // {b,a} readback
   output logic [15:0]      compare_ceiling,         // channel a for ceiling
   output logic [1:0]       compare_flag,            // compare flags
   output logic [1:0]       compare_irq,             // compare irq
   output logic [1:0]       compare_output_level,    // internal level
   output logic [1:0]       compare_match            // qualified match pulse
);
   localparam int N = tcc_pkg::NUM_CH;
   localparam int W = tcc_pkg::CNT_W;
   localparam int B = tcc_pkg::BYTE_W;

   // ******************************************************
   // input synchronisers
   // ******************************************************
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 2'h0;
         sync2_reg <= 2'h0;
      end else if (clk_en) begin
         sync1_reg <= {comparator_output, capture_pin};
         sync2_reg <= sync1_reg;
      end
   end

   // ******************************************************
   // capture trigger and filter
   // ******************************************************
   logic src_sel;
   logic filt_out;
   logic cap_in;
   logic icr_top;
   // pin driven by its own port also feeds here
   assign src_sel = comparator_capture_select ? sync2_reg[1] : sync2_reg[0];

   tcc_filter #(.LEN(tcc_pkg::FILT_LEN)) u_filter (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .din     (src_sel),
      .dout    (filt_out)
   );

   assign cap_in = capture_filter_enable ? filt_out : src_sel;

   // modes using capture register as ceiling
   assign icr_top = (waveform_mode == tcc_pkg::WGM_PFC_ICR)
                  | (waveform_mode == tcc_pkg::WGM_PC_ICR)
                  | (waveform_mode == tcc_pkg::WGM_CTC_ICR)
                  | (waveform_mode == tcc_pkg::WGM_FAST_ICR);

   // ******************************************************
   // capture edge detect and register
   // ******************************************************
   logic        prev_reg;
   logic        prev_next;
   logic [15:0] capv_reg;
   logic [15:0] capv_next;
   logic        capf_reg;
   logic        capf_next;
   logic        capirq_reg;
   logic        capirq_next;
   logic        cap_evt;

   always_comb begin
      prev_next = cap_in;
      cap_evt   = 1'b0;
      // edge detector off in ceiling modes
      // a source switch shows here as an edge
      if (!icr_top && (prev_reg != cap_in)) begin
         cap_evt = (cap_in == capture_edge_rising);
      end
      capv_next = capv_reg;
      if (cap_evt) begin
         capv_next = count_value;
      end
      capf_next = capf_reg;
      // write one clears; set wins over clear
      if (capture_flag_clr || capture_irq_ack) begin
         capf_next = 1'b0;
      end
      if (cap_evt) begin
         capf_next = 1'b1;
      end
      capirq_next = capf_next & capture_irq_enable;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prev_reg   <= 1'b0;
         capv_reg   <= tcc_pkg::CMP_RST;
         capf_reg   <= 1'b0;
         capirq_reg <= 1'b0;
      end else if (clk_en) begin
         prev_reg   <= prev_next;
         capv_reg   <= capv_next;
         capf_reg   <= capf_next;
         capirq_reg <= capirq_next;
      end
   end

   assign capture_value = capv_reg;
   assign capture_flag  = capf_reg;
   assign capture_irq   = capirq_reg;

   // ******************************************************
   // compare channels
   // ******************************************************
   logic            pwm_mode;
   logic [7:0]      temp_reg;
   logic [7:0]      temp_next;
   logic            block_reg;
   logic            block_next;
   logic [N-1:0]    match_raw;
   logic [N*W-1:0]  buf_reg;
   logic [N*W-1:0]  buf_next;
   logic [N*W-1:0]  ocr_reg;
   logic [N*W-1:0]  ocr_next;
   logic [N-1:0]    ocf_reg;
   logic [N-1:0]    ocf_next;
   logic [N-1:0]    ocirq_reg;
   logic [N-1:0]    ocirq_next;
   logic [N-1:0]    lvl_reg;
   logic [N-1:0]    lvl_next;
   logic [N-1:0]    pend_reg;
   logic [N-1:0]    pend_next;
   logic [N-1:0]    mpulse_reg;
   logic [N-1:0]    mpulse_next;

   // pwm modes are everything but normal and both ctc modes
   assign pwm_mode = (waveform_mode != tcc_pkg::WGM_NORMAL)
                   & (waveform_mode != tcc_pkg::WGM_CTC_A)
                   & (waveform_mode != tcc_pkg::WGM_CTC_ICR);

   always_comb begin
      temp_next   = temp_reg;
      block_next  = block_reg;
      buf_next    = buf_reg;
      ocr_next    = ocr_reg;
      ocf_next    = ocf_reg;
      lvl_next    = lvl_reg;
      pend_next   = pend_reg;
      mpulse_next = '0;
      // high byte write loads shared latch
      if (|cmp_high_wr) begin
         temp_next = wr_data;
      end
      // count write arms one tick of blocking
      if (count_write) begin
         block_next = 1'b1;
      end else if (timer_tick) begin
         block_next = 1'b0;
      end
      for (int i = 0; i < N; i++) begin
         match_raw[i] = (count_value == ocr_reg[i*W +: W]);
         // low write joins latch into target
         if (cmp_low_wr[i]) begin
            if (pwm_mode) begin
               buf_next[i*W +: W] = {temp_reg, wr_data};
            end else begin
               ocr_next[i*W +: W] = {temp_reg, wr_data};
            end
         end
         // buffered load only at ceiling or floor
         if (pwm_mode && timer_tick && (at_ceiling || at_floor)) begin
            ocr_next[i*W +: W] = buf_reg[i*W +: W];
         end
         // match on blocked tick is dropped
         // count written to ceiling misses that match
         if (timer_tick) begin
            pend_next[i] = match_raw[i] & ~block_reg & ~count_write;
         end
         // ack or write-one clears; set wins
         if (compare_flag_clr[i] || compare_irq_ack[i]) begin
            ocf_next[i] = 1'b0;
         end
         if (timer_tick && pend_reg[i]) begin
            ocf_next[i]    = 1'b1;
            mpulse_next[i] = 1'b1;
         end
         // force acts like a match, no flag
         if ((timer_tick && pend_reg[i])
             || (force_compare_strobe[i] && !pwm_mode)) begin
            case (compare_output_action[2*i +: 2])
               tcc_pkg::ACT_TOGGLE: lvl_next[i] = ~lvl_reg[i];
               tcc_pkg::ACT_CLEAR:  lvl_next[i] = 1'b0;
               tcc_pkg::ACT_SET:    lvl_next[i] = 1'b1;
               default:             lvl_next[i] = lvl_reg[i];
            endcase
         end
      end
      ocirq_next = ocf_next & compare_irq_enable;
   end

   // level never touched by mode change
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         temp_reg   <= '0;
         block_reg  <= 1'b0;
         buf_reg    <= '0;
         ocr_reg    <= '0;
         ocf_reg    <= '0;
         ocirq_reg  <= '0;
         lvl_reg    <= '0;
         pend_reg   <= '0;
         mpulse_reg <= '0;
      end else if (clk_en) begin
         temp_reg   <= temp_next;
         block_reg  <= block_next;
         buf_reg    <= buf_next;
         ocr_reg    <= ocr_next;
         ocf_reg    <= ocf_next;
         ocirq_reg  <= ocirq_next;
         lvl_reg    <= lvl_next;
         pend_reg   <= pend_next;
         mpulse_reg <= mpulse_next;
      end
   end

   // readback straight from buffer or register
   assign compare_value        = pwm_mode ? buf_reg : ocr_reg;
   assign compare_ceiling      = ocr_reg[W-1:0];
   assign compare_flag         = ocf_reg;
   assign compare_irq          = ocirq_reg;
   assign compare_output_level = lvl_reg;
   assign compare_match        = mpulse_reg;
endmodule : tcc_capture_compare

// ==== tcc_cc_properties.sv ====
// assertion checker for the capture/compare block
`timescale 1ns/1ps
module tcc_cc_properties (
   input wire logic        ref_clk,               // clock
   input wire logic        rst,                   // reset
   input wire logic        clk_en,                // enable
   input wire logic        timer_tick,            // tick
   input wire logic [15:0] count_value,           // count
   input wire logic [3:0]  waveform_mode,         // mode
   input wire logic        capture_flag_clr,      // clear
   input wire logic        capture_irq_ack,       // ack
   input wire logic        capture_irq_enable,    // enable
   input wire logic [7:0]  wr_data,               // byte
   input wire logic [1:0]  cmp_high_wr,           // high
   input wire logic [1:0]  cmp_low_wr,            // low
   input wire logic [3:0]  compare_output_action, // action
   input wire logic [1:0]  force_compare_strobe,  // force
   input wire logic        at_ceiling,            // ceiling
   input wire logic        at_floor,              // floor
   input wire logic [15:0] capture_value,         // captured
   input wire logic        capture_flag,          // flag
   input wire logic        capture_irq,           // irq
   input wire logic [31:0] compare_value,         // readback
   input wire logic [15:0] compare_ceiling,       // reg a
   input wire logic [1:0]  compare_output_level   // level
);
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   sequence s_hi_lo;
      cmp_high_wr[0] && clk_en ##1
      cmp_low_wr[0] && clk_en && waveform_mode == tcc_pkg::WGM_NORMAL;
   endsequence
   sequence s_hold_flag;
      capture_flag && !capture_flag_clr && !capture_irq_ack;
   endsequence
   AST_CAP_VALUE: assert property (
      $rose(capture_flag) |-> capture_value == $past(count_value))
      else $error("captured value differs from count");
   AST_CAP_KEEP: assert property (s_hold_flag |=> capture_flag)
      else $error("capture flag lost without clear");
   AST_CAP_IRQ: assert property (
      clk_en |=> capture_irq == (capture_flag && $past(capture_irq_enable)))
      else $error("capture irq does not follow flag");
   // asynchronous clear must show while reset is still high
   AST_RST_LEVEL: assert property (disable iff (1'b0)
      rst |-> compare_output_level == 2'h0)
      else $error("output level not cleared by reset");
   AST_LOW_DIRECT: assert property (
      cmp_low_wr[0] && clk_en && waveform_mode == tcc_pkg::WGM_NORMAL
      |=> compare_ceiling[7:0] == $past(wr_data))
      else $error("direct low byte write lost");
   AST_HIGH_LATCH: assert property (
      s_hi_lo |=> compare_ceiling[15:8] == $past(wr_data, 2))
      else $error("latched high byte not moved");
   AST_BUF_HOLD: assert property (
      waveform_mode == tcc_pkg::WGM_FAST_ICR &&
      !(timer_tick && (at_ceiling || at_floor)) |=> $stable(compare_ceiling))
      else $error("buffered compare loaded off ceiling and floor");
   AST_READ_DIRECT: assert property (
      waveform_mode == tcc_pkg::WGM_NORMAL |->
      compare_value[15:0] == compare_ceiling)
      else $error("readback differs from compare register");
   AST_FORCE_SET: assert property (
      force_compare_strobe[0] && clk_en &&
      waveform_mode == tcc_pkg::WGM_NORMAL &&
      compare_output_action[1:0] == tcc_pkg::ACT_SET
      |-> ##[1:3] compare_output_level[0])
      else $error("forced set did not reach level");
endmodule : tcc_cc_properties
bind tcc_capture_compare tcc_cc_properties tcc_cc_properties_inst (.*);

// ==== tcc_cpu_model.sv ====
// processor side model writing 16-bit compare values
`timescale 1ns/1ps
module tcc_cpu_model (
   input  wire logic  ref_clk,     // system clock
   output logic [7:0] wr_data,     // write byte
   output logic [1:0] cmp_high_wr, // high byte strobes
   output logic [1:0] cmp_low_wr   // low byte strobes
);
   // ****************
   // byte writes
   // ****************
   initial begin
      wr_data = 8'h00;
      cmp_high_wr = 2'h0;
      cmp_low_wr = 2'h0;
   end
   task automatic wr16(input int ch, input logic [15:0] v);
      @(posedge ref_clk) #1;
      wr_data = v[15:8];
      cmp_high_wr[ch] = 1'b1;
      @(posedge ref_clk) #1;
      cmp_high_wr = 2'h0;
      wr_data = v[7:0];
      cmp_low_wr[ch] = 1'b1;
      @(posedge ref_clk) #1;
      cmp_low_wr = 2'h0;
      // stale byte must not look valid after the write
      wr_data = ~v[7:0];
   endtask : wr16
endmodule : tcc_cpu_model

// ==== tb.sv ====
// self-checking bench for the capture/compare block
`timescale 1ns/1ps
module tb;
   // ****************
   // bench
   // ****************
   logic        ref_clk, rst, clk_en, timer_tick, count_write, at_ceiling;
   logic        capture_pin, comparator_output, comparator_capture_select;
   logic        capture_filter_enable, capture_edge_rising, at_floor;
   logic        capture_flag_clr, capture_irq_ack, capture_irq_enable;
   logic        capture_flag, capture_irq;
   logic [15:0] count_value, capture_value, compare_ceiling;
   logic [31:0] compare_value;
   logic [7:0]  wr_data;
   logic [3:0]  waveform_mode, compare_output_action;
   logic [1:0]  compare_flag_clr, compare_irq_ack, compare_irq_enable;
   logic [1:0]  force_compare_strobe, cmp_high_wr, cmp_low_wr;
   logic [1:0]  compare_flag, compare_irq, compare_output_level, compare_match;
   int          n_errors = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          lat0, lat1;
   tcc_capture_compare tcc_capture_compare_inst (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
      .timer_tick(timer_tick), .count_value(count_value),
      .count_write(count_write), .waveform_mode(waveform_mode),
      .capture_pin(capture_pin), .comparator_output(comparator_output),
      .comparator_capture_select(comparator_capture_select),
      .capture_filter_enable(capture_filter_enable),
      .capture_edge_rising(capture_edge_rising),
      .capture_flag_clr(capture_flag_clr), .capture_irq_ack(capture_irq_ack),
      .capture_irq_enable(capture_irq_enable), .wr_data(wr_data),
      .cmp_high_wr(cmp_high_wr), .cmp_low_wr(cmp_low_wr),
      .compare_flag_clr(compare_flag_clr), .compare_irq_ack(compare_irq_ack),
      .compare_irq_enable(compare_irq_enable),
      .compare_output_action(compare_output_action),
      .force_compare_strobe(force_compare_strobe),
      .at_ceiling(at_ceiling), .at_floor(at_floor),
      .capture_value(capture_value), .capture_flag(capture_flag),
      .capture_irq(capture_irq), .compare_value(compare_value),
      .compare_ceiling(compare_ceiling), .compare_flag(compare_flag),
      .compare_irq(compare_irq), .compare_match(compare_match),
      .compare_output_level(compare_output_level));
   tcc_cpu_model tcc_cpu_model_inst (.ref_clk(ref_clk), .wr_data(wr_data),
      .cmp_high_wr(cmp_high_wr), .cmp_low_wr(cmp_low_wr));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         results();
      end
   end
   task automatic results;
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   task automatic check(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic cyc_n(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc_n
   task automatic wait_cap(output int k);
      k = 0;
      while (capture_flag !== 1'b1 && k < 30) begin
         cyc_n(1);
         k++;
      end
   endtask : wait_cap
   task automatic clr_cap;
      capture_flag_clr = 1'b1;
      cyc_n(1);
      capture_flag_clr = 1'b0;
   endtask : clr_cap
   task automatic tick(input logic wr);
      timer_tick = 1'b1;
      count_write = wr;
      cyc_n(1);
      {timer_tick, count_write} = 2'h0;
      cyc_n(2);
   endtask : tick
   task automatic t_capture;
      for (int s = 0; s < 2; s++) begin
         comparator_capture_select = s[0];
         cyc_n(4);
         clr_cap();
         count_value = 16'h1100 + 16'(s);
         {capture_pin, comparator_output} = {~s[0], s[0]};
         wait_cap(lat0);
         check("cap flag", capture_flag, 1'b1);
         check("cap value", capture_value, 16'h1100 + 16'(s));
         {capture_pin, comparator_output} = 2'h0;
         cyc_n(8);
         count_value = 16'h2200;
         {capture_pin, comparator_output} = {~s[0], s[0]};
         cyc_n(8);
         check("cap overwrite", capture_value, 16'h2200);
         check("cap irq", capture_irq, 1'b1);
         capture_flag_clr = (s == 0);
         capture_irq_ack = (s == 1);
         cyc_n(1);
         {capture_flag_clr, capture_irq_ack} = 2'h0;
         cyc_n(1);
         check("cap clear", capture_flag, 1'b0);
         {capture_pin, comparator_output} = 2'h0;
         cyc_n(8);
      end
   endtask : t_capture
   task automatic t_filter;
      capture_filter_enable = 1'b1;
      comparator_capture_select = 1'b0;
      capture_pin = 1'b1;
      cyc_n(3);
      capture_pin = 1'b0;
      cyc_n(12);
      check("glitch", capture_flag, 1'b0);
      capture_pin = 1'b1;
      wait_cap(lat1);
      check("filter delay", lat1 - lat0, 4);
      // set count, flip edge, then clear flag
      count_value = 16'h3300;
      capture_edge_rising = 1'b0;
      clr_cap();
      capture_pin = 1'b0;
      cyc_n(12);
      check("falling flag", capture_flag, 1'b1);
      check("falling cap", capture_value, 16'h3300);
      capture_edge_rising = 1'b1;
      clr_cap();
   endtask : t_filter
   task automatic t_compare;
      tcc_cpu_model_inst.wr16(0, 16'h1234);
      tcc_cpu_model_inst.wr16(1, 16'habcd);
      check("cmp read", compare_value, 32'habcd1234);
      check("ceiling", compare_ceiling, 16'h1234);
      count_value = 16'h1234;
      tick(1'b1);
      tick(1'b0);
      check("blocked", compare_flag, 2'h0);
      tick(1'b0);
      timer_tick = 1'b1;
      cyc_n(1);
      check("match pulse", compare_match, 2'h1);
      timer_tick = 1'b0;
      cyc_n(2);
      check("match flag", compare_flag, 2'h1);
      check("match irq", compare_irq, 2'h1);
      compare_irq_ack = 2'h1;
      cyc_n(1);
      compare_irq_ack = 2'h0;
      cyc_n(1);
      check("ack clear", compare_flag, 2'h0);
      tick(1'b0);
      compare_flag_clr = 2'h1;
      cyc_n(1);
      compare_flag_clr = 2'h0;
      cyc_n(1);
      check("write clear", compare_flag, 2'h0);
      count_value = 16'h0000;
   endtask : t_compare
   task automatic t_force;
      logic [1:0] act [3] = '{tcc_pkg::ACT_SET, tcc_pkg::ACT_CLEAR,
                              tcc_pkg::ACT_TOGGLE};
      logic       lvl [3] = '{1'b1, 1'b0, 1'b1};
      // level set up by force strobes in normal mode
      for (int i = 0; i < 3; i++) begin
         compare_output_action = {2'h0, act[i]};
         force_compare_strobe = 2'h1;
         cyc_n(1);
         force_compare_strobe = 2'h0;
         cyc_n(2);
         check("force level", compare_output_level, {1'b0, lvl[i]});
         check("force flag", compare_flag, 2'h0);
      end
      waveform_mode = tcc_pkg::WGM_FAST_ICR;
      force_compare_strobe = 2'h1;
      cyc_n(1);
      force_compare_strobe = 2'h0;
      cyc_n(2);
      check("mode keeps level", compare_output_level, 2'h1);
   endtask : t_force
   task automatic t_buffer;
      tcc_cpu_model_inst.wr16(0, 16'h5678);
      check("buf read", compare_value[15:0], 16'h5678);
      tick(1'b0);
      check("buf hold", compare_ceiling, 16'h1234);
      at_ceiling = 1'b1;
      tick(1'b0);
      at_ceiling = 1'b0;
      check("load ceiling", compare_ceiling, 16'h5678);
      tcc_cpu_model_inst.wr16(0, 16'h9abc);
      at_floor = 1'b1;
      tick(1'b0);
      at_floor = 1'b0;
      check("load floor", compare_ceiling, 16'h9abc);
      capture_pin = 1'b1;
      cyc_n(12);
      check("ceiling mode no cap", capture_flag, 1'b0);
      capture_pin = 1'b0;
      cyc_n(12);
   endtask : t_buffer
   initial begin
      {rst, clk_en, capture_edge_rising, capture_irq_enable} = 4'hf;
      {timer_tick, count_write, capture_pin, comparator_output} = 4'h0;
      {comparator_capture_select, capture_filter_enable} = 2'h0;
      {capture_flag_clr, capture_irq_ack, at_ceiling, at_floor} = 4'h0;
      {compare_flag_clr, compare_irq_ack, force_compare_strobe} = 6'h00;
      compare_irq_enable = 2'h1;
      compare_output_action = 4'h0;
      waveform_mode = tcc_pkg::WGM_NORMAL;
      count_value = 16'h0000;
      cyc_n(10);
      check("reset level", compare_output_level, 2'h0);
      rst = 1'b0;
      cyc_n(1);
      t_capture();
      t_filter();
      t_compare();
      t_force();
      t_buffer();
      results();
   end
endmodule : tb
